// file: hdl/ahp_port.sv
// byte-wide host port of the converter
`timescale 1ns/1ps
`include "ahp_map.svh"
module ahp_port #(
  parameter int RES_W = 12
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // host strobes and selects (pins)
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_control_register_select,
  input wire logic i_upper_byte_select,
  input wire logic i_cal_n,
  // data bus
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  // status and converter side
  output logic o_busy_n,
  input wire logic [RES_W-1:0] i_sample,
  output logic o_sleep,
  output logic o_hold_control,
  output logic o_output_latch
);
  import ahp_pkg::*;
  ahp_seq_if sq();

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] s1_ff, s2_ff, s3_ff;
  logic [7:0] d1_ff, d2_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_ff <= 6'h3F;
      s2_ff <= 6'h3F;
      s3_ff <= 6'h3F;
      d1_ff <= 8'h00;
      d2_ff <= 8'h00;
    end else begin
      s1_ff <= {i_cs_n, i_rd_n, i_wr_n, i_control_register_select, i_upper_byte_select, i_cal_n};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      d1_ff <= i_data;
      d2_ff <= d1_ff;
    end
  end
  logic cs_n, rd_n, wr_n, rsel, usel, cal, wr_p, cal_p;
  assign cs_n = s2_ff[5];
  assign rd_n = s2_ff[4];
  assign wr_n = s2_ff[3];
  assign rsel = s2_ff[2];
  assign usel = s2_ff[1];
  assign cal = s2_ff[0];
  assign wr_p = !s3_ff[3] && !s3_ff[5] && s3_ff[4] && cal;
  logic wr_rise;
  assign wr_rise = wr_p && wr_n && !s3_ff[5];
  assign cal_p = cal && !s3_ff[0];

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [7:0] ctrl_ff;
  logic ctrl_wr, trim_req;
  assign ctrl_wr = !cs_n && !wr_n && rd_n && rsel && usel && cal && !sq.busy;
  assign trim_req = ctrl_wr && d2_ff[`AHP_BIT_TRIM];
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_ff <= `AHP_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_ff <= d2_ff; // [R4]
      ctrl_ff[`AHP_BIT_TRIM] <= 1'b0;
    end
  end

  // ----------------------------------------
  // starts
  // ----------------------------------------
  logic hold_mode;
  assign hold_mode = ctrl_ff[`AHP_BIT_HOLD]; // [R11]
  // a write rising edge with register-select low starts a conversion unless in hold control mode
  assign sq.start_conv = ((wr_rise && !s3_ff[2] && !hold_mode) || pend_conv_ff) && !sq.busy; // [R1] [R4] [R8]
  logic wr_sfr_rise;
  assign wr_sfr_rise = wr_rise && s3_ff[2] && s3_ff[1] && !sq.busy; // [R4]
  logic wr_sfr_rise_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_sfr_rise_ff <= 1'b0;
    end else begin
      wr_sfr_rise_ff <= wr_sfr_rise;
    end
  end
  logic trim_pend_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trim_pend_ff <= 1'b0;
    end else if (trim_req) begin
      trim_pend_ff <= 1'b1; // [R11]
    end else if (sq.start_cal) begin
      trim_pend_ff <= 1'b0;
    end
  end
  assign sq.start_cal = cal_p || (trim_pend_ff && wr_sfr_rise_ff); // [R10] [R11]
  // second start path: control write edge when not calibrating and not in hold control mode
  logic conv_after_sfr;
  assign conv_after_sfr = wr_sfr_rise_ff && !trim_pend_ff && !hold_mode;

  ahp_seq u_seq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .sq(sq.seq)
  );

  // delayed start for control writes, ignored while busy
  logic pend_conv_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_conv_ff <= 1'b0;
    end else if (conv_after_sfr && !sq.busy) begin
      pend_conv_ff <= 1'b1; // [R4]
    end else begin
      pend_conv_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // result and read mux
  // ----------------------------------------
  logic [RES_W-1:0] res_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      res_ff <= '0;
    end else if (sq.done) begin
      res_ff <= i_sample;
    end
  end
  logic [15:0] res16;
  assign res16 = 16'(res_ff);
  // byte views of the result
  logic [7:0] res_lo, res_hi;
  assign res_lo = res16[7:0];
  assign res_hi = res16[15:8];
  logic rd_act;
  assign rd_act = !cs_n && !rd_n && wr_n && cal;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data <= 8'h00;
      o_data_oe_n <= 1'b1;
    end else begin
      o_data_oe_n <= !rd_act; // [R9]
      if (!rsel && !usel) begin
        o_data <= res16[7:0]; // [R2]
      end else if (!rsel) begin
        o_data <= res16[15:8]; // [R3]
      end else if (usel) begin
        o_data <= ctrl_ff; // [R5]
      end else begin
        o_data <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy_n <= 1'b1;
      o_sleep <= 1'b0;
      o_hold_control <= 1'b0;
      o_output_latch <= 1'b0;
    end else begin
      o_busy_n <= !(sq.busy || pend_conv_ff); // [R8]
      o_sleep <= ctrl_ff[`AHP_BIT_SLEEP] && !sq.busy; // [R11]
      o_hold_control <= ctrl_ff[`AHP_BIT_HOLD];
      o_output_latch <= ctrl_ff[`AHP_BIT_LATCH];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_busy_on_conv: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R8]
    sq.start_conv |=> sq.busy) else $error("busy not set after start");
  a_busy_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R8]
    sq.busy |-> ##1 !o_busy_n) else $error("busy pin not low");
  a_no_start_busy: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R8]
    sq.busy |-> !sq.start_conv) else $error("start accepted while busy");
  a_float_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R9]
    (cs_n && cal) |=> o_data_oe_n) else $error("bus driven when deselected");
  a_cal_edge: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R10]
    cal_p |=> (u_seq.state_ff == AHP_CAL)) else $error("calibration not started");
  a_low_byte: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R2]
    (rd_act && !rsel && !usel) |=> (o_data == $past(res_lo) && !o_data_oe_n))
    else $error("low byte wrong");
  a_high_byte: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R3]
    (rd_act && !rsel && usel) |=> (o_data == $past(res_hi)))
    else $error("high byte wrong");
  a_ctrl_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R5]
    (rd_act && rsel && usel) |=> (o_data == $past(ctrl_ff))) else $error("control read wrong");
  a_ctrl_store: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R4]
    (ctrl_wr && !d2_ff[`AHP_BIT_TRIM]) |=> (ctrl_ff == $past(d2_ff))) else $error("control not stored");
  a_conv_start: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R1]
    (wr_rise && !s3_ff[2] && !sq.busy && !hold_mode) |=> sq.busy) else $error("write edge no conversion");
  a_sfr_conv: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R4]
    pend_conv_ff |=> sq.busy) else $error("control write no conversion");
  a_trim_cal: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R11]
    (trim_pend_ff && wr_sfr_rise_ff) |=> (u_seq.state_ff == AHP_CAL)) else $error("trim bit no calibration");
  a_sleep_out: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R11]
    (ctrl_ff[`AHP_BIT_SLEEP] && !sq.busy) |=> o_sleep) else $error("sleep output low");
  a_read_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R2]
    rd_act |=> !o_data_oe_n) else $error("bus not driven on read");

  // ----------------------------------------
  // coverage
  // ----------------------------------------
  c_conv: cover property (@(posedge i_clk) sq.start_conv);
  c_cal: cover property (@(posedge i_clk) cal_p);
  c_ctrl: cover property (@(posedge i_clk) ctrl_wr);
  c_done: cover property (@(posedge i_clk) sq.done);
  c_sfr_conv: cover property (@(posedge i_clk) pend_conv_ff);
endmodule

// file: hdl/ahp_map.svh
// constants for the byte-wide converter host port
// What this block does
// R1: a rising write strobe with chip select low, read high, register-select low, calibration high and busy high starts a conversion unless in hold mode.
// R2: a read with register-select low and byte-select low drives the lower result byte.
// R3: a read with register-select low and byte-select high drives the upper result byte.
// R4: a write with register-select and byte-select high stores the bus byte in the control register; its rising edge starts a conversion if bits 1 and 2 are 0.
// R5: a read with register-select and byte-select high drives the control register.
// R6: the host never writes with register-select high and byte-select low.
// R7: the host adds a calibration after power-on if the reference settled late.
// R8: busy is low during a conversion or calibration and start requests other than a calibration input edge are then ignored.
// R9: with chip select high and calibration high the data bus floats.
// R10: a rising edge on the calibration input starts a calibration whatever the other lines are.
// R11: control bit three is sleep, bit one starts calibration, bit two selects hold control, bit zero selects latched output.
`ifndef AHP_MAP_SVH
`define AHP_MAP_SVH
`define AHP_BIT_LATCH 0
`define AHP_BIT_TRIM 1
`define AHP_BIT_HOLD 2
`define AHP_BIT_SLEEP 3
`define AHP_CTRL_RST 8'h00
`define AHP_CONV_CYC 16'h000D
`define AHP_CAL_CYC 16'h00B9
`define AHP_REF_SETTLE_CYC 33056
`endif

// file: hdl/ahp_pkg.sv
// types for the converter host port
package ahp_pkg;
  typedef enum logic [2:0] {
    AHP_IDLE = 3'b001,
    AHP_CONV = 3'b010,
    AHP_CAL = 3'b100
  } ahp_state_t;
endpackage

// file: hdl/ahp_seq_if.sv
// handshake between the port decoder and the sequencer
`timescale 1ns/1ps
interface ahp_seq_if;
  logic start_conv;
  logic start_cal;
  logic busy;
  logic done;
  modport port (output start_conv, output start_cal, input busy, input done);
  modport seq (input start_conv, input start_cal, output busy, output done);
endinterface

// file: hdl/ahp_seq.sv
// conversion and calibration sequencer
`timescale 1ns/1ps
`include "ahp_map.svh"
module ahp_seq (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  ahp_seq_if.seq sq
);
  import ahp_pkg::*;
  ahp_state_t state_ff;
  logic [15:0] cnt_ff;

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= AHP_IDLE;
      cnt_ff <= 16'h0000;
    end else begin
      case (state_ff)
        AHP_IDLE: begin
          if (sq.start_cal) begin // [R10]
            state_ff <= AHP_CAL;
            cnt_ff <= `AHP_CAL_CYC;
          end else if (sq.start_conv) begin
            state_ff <= AHP_CONV;
            cnt_ff <= `AHP_CONV_CYC;
          end
        end
        AHP_CONV, AHP_CAL: begin
          if (sq.start_cal) begin // [R10]
            state_ff <= AHP_CAL;
            cnt_ff <= `AHP_CAL_CYC;
          end else if (cnt_ff == 16'h0001) begin
            state_ff <= AHP_IDLE;
            cnt_ff <= 16'h0000;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        default: state_ff <= AHP_IDLE;
      endcase
    end
  end

  assign sq.busy = (state_ff != AHP_IDLE); // [R8]
  assign sq.done = (state_ff == AHP_CONV) && (cnt_ff == 16'h0001) && !sq.start_cal;
endmodule

// file: tb/ahp_host.sv
// host microprocessor bus model for the converter host port
`timescale 1ns/1ps
module ahp_host (
  // clock
  input wire logic i_clk,
  // strobes, selects and bus toward the port
  output logic o_cs_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_rsel,
  output logic o_usel,
  output logic o_cal_n,
  output logic [7:0] o_data
);
  // ---------------------------------------------
  // idle levels, bus released
  // ---------------------------------------------
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_rsel = 1'b0;
    o_usel = 1'b0;
    o_cal_n = 1'b1;
    o_data = 8'hA5;
  end
  task automatic go(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // ---------------------------------------------
  // bus cycles, never select high with byte low on a write
  // ---------------------------------------------
  task automatic wr(input logic rs, input logic us, input logic [7:0] d);
    o_rsel = rs;
    o_usel = us | rs;
    o_data = d;
    o_cs_n = 1'b0;
    o_wr_n = 1'b0;
    go(4);
    o_wr_n = 1'b1;
    go(4);
    o_cs_n = 1'b1;
    o_data = ~d;
    go(1);
  endtask
  task automatic rd_on(input logic rs, input logic us);
    o_rsel = rs;
    o_usel = us;
    o_cs_n = 1'b0;
    o_rd_n = 1'b0;
  endtask
  task automatic rd_off();
    o_rd_n = 1'b1;
    o_cs_n = 1'b1;
  endtask
  // extra calibration pulse after power-on
  task automatic cal();
    o_cal_n = 1'b0;
    go(4);
    o_cal_n = 1'b1;
    go(1);
  endtask
endmodule

// file: tb/tb_adc_byte_wide_host_port.sv
// self-checking bench of the converter host port
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin err_total++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_adc_byte_wide_host_port;
  logic i_clk, i_rst_n, cs_n, rd_n, wr_n, rsel, usel, cal_n, oe_n, busy_n, sleep, hold, latch;
  logic [7:0] hdata, o_data, d;
  logic [11:0] sample;
  int err_total, n_checks, c;
  ahp_port i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_control_register_select(rsel), .i_upper_byte_select(usel), .i_cal_n(cal_n), .i_data(hdata),
    .o_data(o_data), .o_data_oe_n(oe_n), .o_busy_n(busy_n), .i_sample(sample), .o_sleep(sleep),
    .o_hold_control(hold), .o_output_latch(latch));
  ahp_host i_host (.i_clk(i_clk), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_rsel(rsel),
    .o_usel(usel), .o_cal_n(cal_n), .o_data(hdata));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic rd(input logic rs, input logic us, output logic [7:0] v);
    i_host.rd_on(rs, us);
    i_host.go(5);
    `CHK("oe_n", 1'b0, oe_n)
    v = o_data;
    i_host.rd_off();
    i_host.go(5);
    `CHK("float", 1'b1, oe_n)
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    c = 0;
    while (busy_n !== lvl && c < lim) begin
      i_host.go(1);
      c++;
    end
    `CHK("busy_n", lvl, busy_n)
  endtask
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    i_rst_n = 1'b0;
    sample = 12'hA5C;
    i_host.go(8);
    i_rst_n = 1'b1;
    `CHK("rst oe", 1'b1, oe_n)
    `CHK("rst busy", 1'b1, busy_n)
    i_host.go(4);
    i_host.cal();
    wait_busy(1'b0, 10);
    i_host.go(100);
    `CHK("cal busy", 1'b0, busy_n)
    wait_busy(1'b1, 200);
    $display("test calibration done");
    i_host.wr(1'b0, 1'b0, 8'h00);
    wait_busy(1'b0, 10);
    i_host.wr(1'b0, 1'b0, 8'h00);
    wait_busy(1'b1, 30);
    sample = 12'h3F1;
    i_host.go(12);
    `CHK("no restart", 1'b1, busy_n)
    rd(1'b0, 1'b0, d);
    `CHK("low byte", 8'h5C, d)
    rd(1'b0, 1'b1, d);
    `CHK("high byte", 8'h0A, d)
    $display("test conversion done");
    i_host.wr(1'b1, 1'b1, 8'h05);
    i_host.go(10);
    `CHK("hold no start", 1'b1, busy_n)
    `CHK("hold", 1'b1, hold)
    `CHK("latch", 1'b1, latch)
    rd(1'b1, 1'b1, d);
    `CHK("ctrl rd", 8'h05, d)
    rd(1'b1, 1'b0, d);
    `CHK("reserved", 8'h00, d)
    i_host.wr(1'b1, 1'b1, 8'h08);
    wait_busy(1'b0, 10);
    wait_busy(1'b1, 30);
    `CHK("sleep", 1'b1, sleep)
    `CHK("hold off", 1'b0, hold)
    `CHK("latch off", 1'b0, latch)
    rd(1'b0, 1'b0, d);
    `CHK("sfr low byte", 8'hF1, d)
    rd(1'b0, 1'b1, d);
    `CHK("sfr high byte", 8'h03, d)
    i_rst_n = 1'b0;
    i_host.go(2);
    i_rst_n = 1'b1;
    i_host.go(4);
    `CHK("rst sleep", 1'b0, sleep)
    rd(1'b1, 1'b1, d);
    `CHK("rst ctrl", 8'h00, d)
    $display("test reset done");
    i_host.wr(1'b1, 1'b1, 8'h02);
    wait_busy(1'b0, 10);
    i_host.go(100);
    `CHK("trim busy", 1'b0, busy_n)
    wait_busy(1'b1, 200);
    `CHK("wake", 1'b0, sleep)
    rd(1'b1, 1'b1, d);
    `CHK("trim clr", 8'h00, d)
    $display("test control done");
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    $display("BAD watchdog exp done got hang");
    complete_run();
  end
endmodule
